/* File: hdl/rsh_pkg.sv */
package rsh_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] SWITCH_CTRL_IDX = 10'h01c;
  localparam logic [9:0] HOLD_CTRL_IDX   = 10'h01d;
  localparam logic [9:0] STATUS_IDX      = 10'h01f;
  localparam int         ADDR_LSB        = 2;
  localparam int         ADDR_W          = 12;

  // Switchover control fields
  localparam int DEGLITCH_OFF_BIT = 7;
  localparam int SELECT_B_BIT     = 6;
  localparam int USE_PIN_BIT      = 5;
  localparam int AUTO_SWITCH_BIT  = 4;
  localparam int STAY_ON_B_BIT    = 3;
  localparam int POWER_B_BIT      = 2;
  localparam int POWER_A_BIT      = 1;
  localparam int DIFF_MODE_BIT    = 0;

  // Holdover control fields
  localparam int STATUS_OFF_BIT   = 4;
  localparam int LD_COMP_EN_BIT   = 3;
  localparam int HOLD_EN_BIT      = 2;
  localparam int EXT_HOLD_BIT     = 1;
  localparam int HOLD_EN2_BIT     = 0;

  // Status fields
  localparam int STAT_HOLD_BIT    = 5;
  localparam int STAT_REF_B_BIT   = 4;
  localparam int STAT_REF_B_OK    = 2;
  localparam int STAT_REF_A_OK    = 1;
  localparam int STAT_LOCK_BIT    = 0;

  localparam logic [7:0] SWITCH_CTRL_RESET = 8'h00;
  localparam logic [7:0] HOLD_CTRL_RESET   = 8'h00;

  // Deglitch: selection change waits this many cycles of steadiness
  localparam int         DEGLITCH_NS     = 400;
  localparam int         CLK_MHZ         = 20;
  localparam int         DEGLITCH_CYC    = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] DEGLITCH_COUNT  = 4'(DEGLITCH_CYC);

  typedef enum logic [1:0] {HO_IDLE, HO_LOCKED, HO_HOLD} rsh_hold_type;
endpackage

/* File: hdl/rsh_switchover_ctrl.sv */
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
// Function
// - Switchover bit 7 set disables the selection deglitch; reset clear.
// - Register manual select: bit 6 zero picks input A, one picks B.
// - Manual mode bit 5 picks source: bit 6 or reference select pin.
// - Bit 4 chooses manual or automatic switchover; auto needs single-ended mode.
// - Bit 3 zero returns to A once good; one stays on B.
// - Without auto switchover, bit 2 powers input B; default off.
// - Without auto switchover, bit 1 powers input A; default off.
// - Bit 0 picks single-ended or differential; auto and B need single-ended.
// - Holdover bit 4 set blocks status register readback.
// - Holdover bit 3 enables comparator; off means lock detect is treated true.
// - Automatic holdover with comparator uses it to judge previous lock.
// - Holdover active only with both bit 2 and bit 0 set.
// - Holdover bit 1 set: sync pin drives holdover, internal controller bypassed.
// - Holdover bit 0 is the second enable, paired with bit 2.
// - Status bit reports current reference: zero A or differential, one B.
module rsh_switchover_ctrl
  import rsh_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  // Register bus
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [rsh_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Reference pins and monitors
  input  wire logic                refSelectPin,
  input  wire logic                refAGood,
  input  wire logic                refBGood,
  input  wire logic                digitalLock,
  input  wire logic                lockDetectPinHigh,
  input  wire logic                syncPinHold,
  // Mux, power and holdover controls
  output logic                     refBSelected,
  output logic                     refAPowerOn,
  output logic                     refBPowerOn,
  output logic                     diffMode,
  output logic                     holdoverActive,
  output logic                     ldComparatorOn
);
  import rsh_pkg::*;

  // State
  logic [7:0]   switchCtrl_reg;
  logic [7:0]   holdCtrl_reg;
  logic         autoOnB_reg;
  logic         refBSel_reg;
  logic [3:0]   glitchCnt_reg;
  logic         holdAct_reg;
  rsh_hold_type holdState_reg;
  logic         ack_reg;
  logic [31:0]  rdData_reg;

  // Decode and control helpers
  logic [9:0]   regIdx;
  logic         busReq;
  logic         wantB;
  logic         autoMode;
  logic         holdEnabled;
  logic         ldTrue;
  logic [7:0]   statusByte;
  logic         wrStrobe;
  logic         switchWrite;
  logic         holdWrite;
  logic [7:0]   readByte;
  logic         failToB;
  logic         returnToA;
  logic         glitchDone;
  logic         selRefGood;
  logic         holdEnter;
  logic         holdStay;

  // Bus decode; ack gates the request so a held cycle is taken only once
  assign regIdx   = wb_adr_i[ADDR_W-1:ADDR_LSB];
  assign busReq   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  // A write lands on the edge that sees ack high, as the master expects
  assign wrStrobe    = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];
  assign switchWrite = wrStrobe && (regIdx == SWITCH_CTRL_IDX);
  assign holdWrite   = wrStrobe && (regIdx == HOLD_CTRL_IDX);

  // Automatic switchover is only honoured in single-ended mode
  assign autoMode = switchCtrl_reg[AUTO_SWITCH_BIT] && !switchCtrl_reg[DIFF_MODE_BIT];

  // Requested reference before the deglitch filter
  always_comb begin
    if (switchCtrl_reg[DIFF_MODE_BIT]) begin
      // Differential mode feeds the loop from the first input pair only
      wantB = 1'b0;
    end else if (autoMode) begin
      // Auto mode follows the switchover tracker
      wantB = autoOnB_reg;
    end else if (switchCtrl_reg[USE_PIN_BIT]) begin
      // Pin select is taken as already synchronous to clk
      wantB = refSelectPin;
    end else begin
      wantB = switchCtrl_reg[SELECT_B_BIT];
    end
  end

  // Switchover control register; only byte lane 0 carries the 8-bit registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      switchCtrl_reg <= SWITCH_CTRL_RESET;
    end else if (switchWrite) begin
      switchCtrl_reg <= wb_dat_i[7:0];
    end
  end

  // Holdover control register; writes with lane 0 off leave it untouched
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      holdCtrl_reg <= HOLD_CTRL_RESET;
    end else if (holdWrite) begin
      holdCtrl_reg <= wb_dat_i[7:0];
    end
  end

  // Single wait-state ack: one cycle after the request is taken, never longer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busReq;
    end
  end

  // Read byte selection; unmapped addresses read zero and still ack
  always_comb begin
    readByte = 8'h00;
    unique case (regIdx)
      SWITCH_CTRL_IDX: begin
        readByte = switchCtrl_reg;
      end
      HOLD_CTRL_IDX: begin
        readByte = holdCtrl_reg;
      end
      STATUS_IDX: begin
        // Blocked readback leaves the whole word zero
        if (holdCtrl_reg[STATUS_OFF_BIT]) begin
          readByte = 8'h00;
        end else begin
          readByte = statusByte;
        end
      end
      default: begin
        readByte = 8'h00;
      end
    endcase
  end

  // Read data is captured when the request is taken and holds until the next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_reg <= 32'h0;
    end else if (busReq && !wb_we_i) begin
      rdData_reg <= {24'h0, readByte};
    end
  end

  // Status byte; writes to it are ignored
  always_comb begin
    // Bits this block does not own read zero
    statusByte                 = 8'h00;
    statusByte[STAT_HOLD_BIT]  = holdAct_reg;
    statusByte[STAT_REF_B_BIT] = refBSel_reg;
    // Input health and lock pass straight through
    statusByte[STAT_REF_B_OK]  = refBGood;
    statusByte[STAT_REF_A_OK]  = refAGood;
    statusByte[STAT_LOCK_BIT]  = digitalLock;
  end

  // Auto switchover events: A failing with B healthy, and A healthy again
  assign failToB   = !autoOnB_reg && !refAGood && refBGood;
  assign returnToA = autoOnB_reg && refAGood && !switchCtrl_reg[STAY_ON_B_BIT];

  // Automatic switchover: leave A when it fails and B is good
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      autoOnB_reg <= 1'b0;
    end else if (!autoMode) begin
      // Leaving auto mode forgets any earlier move to B
      autoOnB_reg <= 1'b0;
    end else if (failToB) begin
      autoOnB_reg <= 1'b1;
    end else if (returnToA) begin
      // Stay bit set keeps the loop on B even after A recovers
      autoOnB_reg <= 1'b0;
    end
  end

  // Deglitch timer: a new selection must stand steady before the mux moves,
  // trading a short switch delay for no runt pulses into the PLL
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      glitchCnt_reg <= 4'h0;
    end else if (wantB == refBSel_reg) begin
      glitchCnt_reg <= 4'h0;
    end else if (switchCtrl_reg[DEGLITCH_OFF_BIT] || glitchDone) begin
      glitchCnt_reg <= 4'h0;
    end else begin
      glitchCnt_reg <= glitchCnt_reg + 4'h1;
    end
  end

  // The last count of the timer lets the move through
  assign glitchDone = (glitchCnt_reg == DEGLITCH_COUNT - 4'h1);

  // Mux selection moves at once with the filter off, else when the timer runs out
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refBSel_reg <= 1'b0;
    end else if (switchCtrl_reg[DEGLITCH_OFF_BIT]) begin
      refBSel_reg <= wantB;
    end else if (glitchDone) begin
      refBSel_reg <= wantB;
    end
  end

  // Input power: automatic mode needs both inputs alive
  always_comb begin
    if (autoMode) begin
      // Auto mode must watch both inputs, so the power bits are overridden
      refAPowerOn = 1'b1;
      refBPowerOn = 1'b1;
    end else begin
      // Manual mode: software owns power A, and power B in single-ended mode only
      refAPowerOn = switchCtrl_reg[POWER_A_BIT];
      refBPowerOn = switchCtrl_reg[POWER_B_BIT] && !switchCtrl_reg[DIFF_MODE_BIT];
    end
  end

  // Mode and comparator outputs straight from the control bits; selection and holdover from their registers
  assign diffMode       = switchCtrl_reg[DIFF_MODE_BIT];
  assign refBSelected   = refBSel_reg;
  assign ldComparatorOn = holdCtrl_reg[LD_COMP_EN_BIT];
  assign holdEnabled    = holdCtrl_reg[HOLD_EN_BIT] && holdCtrl_reg[HOLD_EN2_BIT];
  assign ldTrue         = holdCtrl_reg[LD_COMP_EN_BIT] ? lockDetectPinHigh : 1'b1;
  assign holdoverActive = holdAct_reg;

  // Health of whichever input feeds the loop right now
  assign selRefGood = refBSel_reg ? refBGood : refAGood;

  // Holdover controller; software must keep it off during VCO calibration
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      holdState_reg <= HO_IDLE;
    end else if (!holdEnabled || holdCtrl_reg[EXT_HOLD_BIT]) begin
      holdState_reg <= HO_IDLE;
    end else begin
      unique case (holdState_reg)
        HO_IDLE: begin
          // Only a lock that the pin comparator agrees with counts
          if (digitalLock && ldTrue) begin
            holdState_reg <= HO_LOCKED;
          end
        end
        HO_LOCKED: begin
          // Reference lost after a good lock: freeze the loop
          if (holdEnter) begin
            holdState_reg <= HO_HOLD;
          end else if (!ldTrue) begin
            holdState_reg <= HO_IDLE;
          end
        end
        HO_HOLD: begin
          // Recover once the selected reference is good again
          if (selRefGood) begin
            holdState_reg <= HO_IDLE;
          end
        end
      endcase
    end
  end

  // Entry into holdover and staying there while the reference stays bad
  assign holdEnter = (holdState_reg == HO_LOCKED) && !selRefGood && ldTrue;
  assign holdStay  = (holdState_reg == HO_HOLD) && !selRefGood;

  // Holdover flag: the sync pin in external mode, else the hold state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      holdAct_reg <= 1'b0;
    end else if (!holdEnabled) begin
      holdAct_reg <= 1'b0;
    end else if (holdCtrl_reg[EXT_HOLD_BIT]) begin
      holdAct_reg <= syncPinHold;
    end else begin
      holdAct_reg <= holdEnter || holdStay;
    end
  end
endmodule // rsh_switchover_ctrl

/* File: tb/rsh_ref_model.sv */
`timescale 1ns/1ps
// Reference sources and sync pin; levels move only just after an edge
module rsh_ref_model (
  input wire logic       clk,
  input wire logic [4:0] env,
  output logic           aGood,
  output logic           bGood,
  output logic           lock,
  output logic           ldHigh,
  output logic           syncHold
);
  always_ff @(posedge clk) {syncHold, ldHigh, lock, bGood, aGood} <= env;
endmodule // rsh_ref_model

/* File: tb/rsh_switchover_ctrl_asserts.sv */
`timescale 1ns/1ps
// Bus answer timing and forced mode outputs, seen only at the top ports
module rsh_switchover_ctrl_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        refBSelected,
  input wire logic        refAPowerOn,
  input wire logic        refBPowerOn,
  input wire logic        diffMode,
  input wire logic        holdoverActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Ack is one pulse, one cycle after a fresh request, never unasked
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  chk_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack without cycle");
  // Registers are a byte wide, so upper read bits must stay clear
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  // Differential mode has no second input: unpowered and soon unselected
  chk_diff_power: assert property (diffMode |-> !refBPowerOn) else $error("B powered");
  chk_diff_select: assert property ($rose(diffMode) |-> ##[0:12] !refBSelected)
    else $error("B kept in diff mode");
  chk_reset_state: assert property ($fell(reset) |-> !refAPowerOn && !refBPowerOn)
    else $error("power on after reset");
  chk_reset_quiet: assert property ($fell(reset) |-> !holdoverActive && !refBSelected)
    else $error("holdover or B selected after reset");
endmodule // rsh_switchover_ctrl_asserts

bind rsh_switchover_ctrl rsh_switchover_ctrl_asserts u_asserts (.clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .refBSelected, .refAPowerOn, .refBPowerOn, .diffMode,
  .holdoverActive);

/* File: tb/test_rsh_switchover_ctrl.sv */
`timescale 1ns/1ps
module test_rsh_switchover_ctrl;
  import rsh_pkg::*;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, pin = 0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h1;
  logic [4:0]  env = 5'h03; // Sync, ld pin, lock, B good, A good
  logic [31:0] dat = 32'h0, rdat, datO, seed = 32'he5fd0483;
  logic ack, aOk, bOk, lock, ldHi, sync, bSel, aPwr, bPwr, diff, hold, ldOn;
  int n_mismatch = 0, checked = 0, cycles = 0;
  always #25 clk = ~clk;
  rsh_ref_model u_src (.clk, .env, .aGood(aOk), .bGood(bOk), .lock, .ldHigh(ldHi), .syncHold(sync));
  rsh_switchover_ctrl u_dut (.clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .refSelectPin(pin), .refAGood(aOk), .refBGood(bOk), .digitalLock(lock),
    .lockDetectPinHigh(ldHi), .syncPinHold(sync), .refBSelected(bSel), .refAPowerOn(aPwr),
    .refBPowerOn(bPwr), .diffMode(diff), .holdoverActive(hold), .ldComparatorOn(ldOn));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Auto switchover needs both inputs up; differential mode drops B
  function automatic logic pwrB(input logic [7:0] v);
    return ~v[DIFF_MODE_BIT] & (v[POWER_B_BIT] | v[AUTO_SWITCH_BIT]);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard, far above the two hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    wb(0, 12'h070, 8'h00);
    cmp("switch reset", 32'h0, rdat);
    wb(0, 12'h100, 8'h00);
    cmp("unmapped", 32'h0, rdat);
    // Random mode words; powers and mode follow the stored bits
    repeat (6) begin
      seed = lfsr(seed);
      wb(1, 12'h070, seed[7:0]);
      wb(0, 12'h070, 8'h00);
      cmp("switch rdbk", {24'h0, seed[7:0]}, rdat);
      cmp("power b", pwrB(seed[7:0]), bPwr);
      cmp("power a", seed[1] | (seed[4] & ~seed[0]), aPwr);
      cmp("diff mode", seed[0], diff);
    end
    // Deglitch holds the move for eight cycles; bit 7 makes it prompt
    wb(1, 12'h070, 8'h00);
    repeat (12) @(posedge clk);
    wb(1, 12'h070, 8'h40);
    repeat (DEGLITCH_CYC) @(posedge clk);
    cmp("deglitch wait", 32'h0, bSel);
    @(posedge clk);
    cmp("select b", 32'h1, bSel);
    wb(1, 12'h070, 8'h80);
    repeat (2) @(posedge clk);
    cmp("no deglitch", 32'h0, bSel);
    wb(1, 12'h070, 8'ha0);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, 12'h07c, 8'h00);
    cmp("status sel", 32'h1, rdat[STAT_REF_B_BIT]);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("pin low", 32'h0, bSel);
    // Automatic mode, kept single-ended
    env <= 5'h02;
    wb(1, 12'h070, 8'h90);
    repeat (4) @(posedge clk);
    cmp("auto to b", 32'h1, bSel);
    env <= 5'h03;
    repeat (4) @(posedge clk);
    cmp("auto back", 32'h0, bSel);
    wb(1, 12'h070, 8'h98);
    env <= 5'h02;
    repeat (4) @(posedge clk);
    env <= 5'h03;
    repeat (4) @(posedge clk);
    cmp("stay on b", 32'h1, bSel);
    wb(1, 12'h070, 8'h80);
    env <= 5'h13;
    wb(1, 12'h074, 8'h07);
    repeat (3) @(posedge clk);
    cmp("ext hold", 32'h1, hold);
    wb(1, 12'h074, 8'h03);
    repeat (3) @(posedge clk);
    cmp("no enable", 32'h0, hold);
    wb(1, 12'h074, 8'h06);
    repeat (3) @(posedge clk);
    cmp("no enable2", 32'h0, hold);
    // Comparator on: a low ld pin means the loop never counted as locked
    env <= 5'h07;
    wb(1, 12'h074, 8'h0d);
    @(posedge clk);
    cmp("comparator", 32'h1, ldOn);
    env <= 5'h06;
    repeat (4) @(posedge clk);
    cmp("ld low", 32'h0, hold);
    env <= 5'h0f;
    repeat (4) @(posedge clk);
    env <= 5'h0e;
    repeat (4) @(posedge clk);
    cmp("ld high", 32'h1, hold);
    env <= 5'h07;
    wb(1, 12'h074, 8'h05);
    repeat (4) @(posedge clk);
    env <= 5'h06;
    repeat (4) @(posedge clk);
    cmp("ld as true", 32'h1, hold);
    env <= 5'h03;
    wb(1, 12'h074, 8'h10);
    wb(0, 12'h07c, 8'h00);
    cmp("status off", 32'h0, rdat);
    sel <= 4'he;
    wb(1, 12'h074, 8'hff);
    sel <= 4'h1;
    wb(0, 12'h074, 8'h00);
    cmp("sel ignored", 32'h10, rdat);
    wrap_up();
  end
endmodule // test_rsh_switchover_ctrl
